// *** design/reply_framer.sv ***
// reply_framer: builds read-data and completion replies, drives their data
// words, classifies packets into ordering streams with unit clumping.
// assumes: core and link logic share clk_i; classic Wishbone register slave.
//
// Notes on behaviour
// - data request gets read-data reply 110000, data words follow after one idle link cycle.
// - count field holds data length in dwords minus one.
// - count copied for dword reads, 0 for byte reads, 1 for atomics.
// - full requested number of data words always driven, even invalid.
// - error code 00 normal, 01 target abort, 10 data error, 11 master abort.
// - master abort reply data words are all ones.
// - data after target abort or data error is flagged unusable.
// - reply isoc flag copied from the request.
// - forwarded peer replies copy the request isoc flag too.
// - source tag copied unchanged from the request.
// - with bridge flag clear, requester id holds requester unit id low bits.
// - channel-set field from request fields, zero for base and isoc sets.
// - no-data requests answered with completion reply 110011.
// - command buffer freed when the completion reply is issued.
// - each nonposted request gets exactly one reply of one type.
// - data error in completion means corrupted write data received.
// - upstream streams separated by unit id, fences belong to every stream.
// - all downstream traffic is one stream.
// - five-bit tag, at most 32 outstanding per unit id.
// - passive clumping orders all upstream unit ids together.
// - full clumping reports wanted ids from bit 1, groups the enabled mask.
// - a host clumps only unit ids 0 to 3.
`timescale 1ns/1ps
`default_nettype none
module reply_framer #(
  parameter logic [31:0] CLUMP_SUPPORT = 32'h00000000,
  parameter bit          IS_HOST       = 1'b0
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // reply request from the core
  input  wire logic        rep_valid_i,
  input  wire logic [1:0]  rep_kind_i,
  input  wire logic [3:0]  rep_count_i,
  input  wire logic [1:0]  rep_error_i,
  input  wire logic        rep_isoc_i,
  input  wire logic        rep_pass_pw_i,
  input  wire logic        rep_bridge_i,
  input  wire logic [4:0]  rep_unit_i,
  input  wire logic [4:0]  rep_req_unit_i,
  input  wire logic [4:0]  rep_tag_i,
  input  wire logic [3:0]  rep_seq_i,
  output logic             rep_ready_o,
  output logic             buf_free_o,
  // reply data from the core
  input  wire logic        data_valid_i,
  input  wire logic [31:0] data_i,
  output logic             data_ack_o,
  // link transmit side
  input  wire logic        link_ready_i,
  output logic             link_valid_o,
  output logic      [31:0] link_word_o,
  output logic             link_hdr_o,
  output logic             link_bad_o,
  // stream classification
  input  wire logic        cls_valid_i,
  input  wire logic        cls_upstream_i,
  input  wire logic        cls_fence_i,
  input  wire logic [4:0]  cls_unit_i,
  output logic             stream_valid_o,
  output logic      [4:0]  stream_o,
  output logic             stream_all_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA} state_t;

  // state
  state_t      state_q,   state_d;
  logic [4:0]  left_q,    left_d;     // data words still to send, minus one
  logic        abort_q,   abort_d;
  logic        bad_q,     bad_d;
  logic        ovalid_q,  ovalid_d;
  logic [31:0] oword_q,   oword_d;
  logic        ohdr_q,    ohdr_d;
  logic        obad_q,    obad_d;
  logic        dack_q,    dack_d;
  logic        free_q,    free_d;
  logic        rdy_q,     rdy_d;
  logic [3:0]  ctrl_q,    ctrl_d;
  logic [31:0] clen_q,    clen_d;
  logic [1:0]  lasterr_q, lasterr_d;
  logic [15:0] nrd_q,     nrd_d;
  logic [15:0] ndone_q,   ndone_d;
  logic [31:0] rdat_q,    rdat_d;
  logic        ack_q,     ack_d;
  logic        svalid_q,  svalid_d;
  logic [4:0]  stream_q,  stream_d;
  logic        sall_q,    sall_d;

  logic        slot_free;
  logic        take_req;
  logic        take_word;
  logic [3:0]  cnt;
  logic [2:0]  channel_set_select;
  logic [1:0]  reqid;
  logic [31:0] hdr;
  logic [31:0] wdata;
  logic        wb_req;

  // count field and channel set for the reply being accepted
  always_comb begin
    case (rep_kind_i)
      reply_pkg::KIND_DWORD_READ: cnt = rep_count_i;
      reply_pkg::KIND_BYTE_READ:  cnt = reply_pkg::COUNT_ONE_DWORD;
      reply_pkg::KIND_ATOMIC:     cnt = reply_pkg::COUNT_ONE_QWORD;
      default:                    cnt = reply_pkg::COUNT_ZERO;
    endcase
    channel_set_select = reply_pkg::CHANNEL_SET_SELECT_NONE; // base and isoc sets leave it zero
    if (rep_isoc_i && !ctrl_q[reply_pkg::CTRL_ISOC_FC]) begin
      if (rep_seq_i <= reply_pkg::SEQ_ALT_MAX)
        channel_set_select = reply_pkg::CHANNEL_SET_SELECT_ALT;
      else if (rep_seq_i == reply_pkg::SEQ_NONFC)
        channel_set_select = reply_pkg::CHANNEL_SET_SELECT_NONFC;
      else if (rep_seq_i == reply_pkg::SEQ_IMPL4)
        channel_set_select = reply_pkg::CHANNEL_SET_SELECT_IMPL4;
      else if (rep_seq_i == reply_pkg::SEQ_RSV_LO ||
               rep_seq_i == reply_pkg::SEQ_RSV_HI)
        channel_set_select = reply_pkg::CHANNEL_SET_SELECT_RSV3;
      else if (rep_seq_i == reply_pkg::SEQ_IMPL6_LO ||
               rep_seq_i == reply_pkg::SEQ_IMPL6_HI)
        channel_set_select = reply_pkg::CHANNEL_SET_SELECT_IMPL6;
      else
        channel_set_select = reply_pkg::CHANNEL_SET_SELECT_STREAM;
    end
    reqid = rep_bridge_i ? 2'h0 : rep_req_unit_i[1:0];
  end

  // control word of the reply, reserved bits left at zero
  always_comb begin
    hdr = 32'h00000000;
    hdr[reply_pkg::HB_CMD +: 6] = (rep_kind_i == reply_pkg::KIND_NO_DATA) ?
      reply_pkg::CMD_COMPLETION_NO_DATA :
      reply_pkg::CMD_READ_DATA_REPLY;
    hdr[reply_pkg::HB_ISOC]      = rep_isoc_i;
    hdr[reply_pkg::HB_UNIT +: 5] = rep_unit_i;
    hdr[reply_pkg::HB_BRIDGE]    = rep_bridge_i;
    hdr[reply_pkg::HB_PASS_POSTED_WRITES_FLAG]    = rep_pass_pw_i;
    hdr[reply_pkg::HB_TAG +: 5]  = rep_tag_i;
    hdr[reply_pkg::HB_ERR0]      = rep_error_i[0];
    hdr[reply_pkg::HB_ERR1]      = rep_error_i[1];
    hdr[reply_pkg::HB_CNTLO +: 2] = cnt[1:0];
    hdr[reply_pkg::HB_CNTHI +: 2] = cnt[3:2];
    hdr[reply_pkg::HB_CHANNEL_SET_SELECT +: 3] = channel_set_select;
    hdr[reply_pkg::HB_REQID +: 2] = reqid;
  end

  // framer sequencing: one reply per accepted request, then its data
  always_comb begin
    slot_free = !ovalid_q || link_ready_i;
    take_req  = rdy_q && rep_valid_i;
    take_word = (state_q == ST_DATA) && slot_free &&
                (abort_q || (data_valid_i && !dack_q));
    state_d  = state_q;
    left_d   = left_q;
    abort_d  = abort_q;
    bad_d    = bad_q;
    ovalid_d = ovalid_q && !link_ready_i;
    oword_d  = oword_q;
    ohdr_d   = ohdr_q;
    obad_d   = obad_q;
    dack_d   = 1'b0;
    free_d   = 1'b0;
    rdy_d    = 1'b0;
    lasterr_d = lasterr_q;
    nrd_d    = nrd_q;
    ndone_d  = ndone_q;
    case (state_q)
      ST_IDLE: begin
        // ready only with an empty output slot, so no word is overwritten
        rdy_d = ctrl_q[reply_pkg::CTRL_ENABLE] && !take_req &&
                !ovalid_d;
        if (take_req) begin
          state_d   = ST_HDR;
          left_d    = {1'b0, cnt};
          abort_d   = rep_error_i == reply_pkg::ERR_MASTER_ABORT;
          bad_d     = rep_error_i != reply_pkg::ERR_NORMAL;
          lasterr_d = rep_error_i;
          oword_d   = hdr;
          ohdr_d    = 1'b1;
          obad_d    = 1'b0;
          ovalid_d  = 1'b1;
          if (rep_kind_i == reply_pkg::KIND_NO_DATA) begin
            free_d  = 1'b1;
            ndone_d = ndone_q + 16'h0001;
            state_d = ST_IDLE;
          end else begin
            nrd_d   = nrd_q + 16'h0001;
          end
        end
      end
      ST_HDR: begin
        // data words follow the read reply after one idle link cycle once it is taken
        if (slot_free) state_d = ST_DATA;
      end
      ST_DATA: begin
        if (take_word) begin
          oword_d  = abort_q ? reply_pkg::ALL_ONES : data_i;
          ohdr_d   = 1'b0;
          obad_d   = bad_q;
          ovalid_d = 1'b1;
          dack_d   = !abort_q;
          if (left_q == 5'h00) state_d = ST_IDLE;
          else left_d = left_q - 5'h01;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // clumping: an enabled bit k joins unit k to the group of unit k-1
  function automatic logic [4:0] clump_base(input logic [4:0] unit,
                                            input logic [31:0] mask);
    logic [4:0] base;
    base = unit;
    for (int i = reply_pkg::NUM_UNITS - 1; i > 0; i--) begin
      if (i[4:0] == base && mask[i]) base = base - 5'h01;
    end
    return base;
  endfunction

  // stream classification for ordering
  always_comb begin
    svalid_d = cls_valid_i;
    sall_d   = cls_valid_i && cls_upstream_i && cls_fence_i;
    stream_d = 5'h00;
    if (cls_upstream_i && !cls_fence_i) begin
      if (ctrl_q[reply_pkg::CTRL_PASSIVE])
        stream_d = 5'h00;
      else if (ctrl_q[reply_pkg::CTRL_FULL])
        stream_d = clump_base(cls_unit_i, clen_q);
      else
        stream_d = cls_unit_i;
    end
  end

  // wishbone register slave, acked one cycle after the request appears
  always_comb begin
    wb_req = cyc_i && stb_i && !ack_q;
    ack_d  = wb_req;
    ctrl_d = ctrl_q;
    clen_d = clen_q;
    rdat_d = 32'h00000000;
    wdata  = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      wdata[b*8 +: 8] = sel_i[b] ? dat_i[b*8 +: 8] : clen_q[b*8 +: 8];
    end
    // writes land on the edge at which the master samples ack high
    if (cyc_i && stb_i && ack_q && we_i) begin
      if (adr_i == reply_pkg::ADDR_CTRL && sel_i[0])
        ctrl_d = dat_i[3:0];
      if (adr_i == reply_pkg::ADDR_CLUMP_EN) begin
        clen_d = wdata & reply_pkg::CLUMP_BIT0_MASK;
        if (IS_HOST)
          clen_d = clen_d & reply_pkg::HOST_CLUMP_LIMIT;
      end
    end
    if (wb_req && !we_i) begin
      case (adr_i)
        reply_pkg::ADDR_CTRL:      rdat_d = {28'h0000000, ctrl_q};
        reply_pkg::ADDR_CLUMP_SUP:
          rdat_d = CLUMP_SUPPORT & reply_pkg::CLUMP_BIT0_MASK;
        reply_pkg::ADDR_CLUMP_EN:  rdat_d = clen_q;
        reply_pkg::ADDR_STATUS:
          rdat_d = {28'h0000000, lasterr_q, ovalid_q, state_q != ST_IDLE};
        reply_pkg::ADDR_COUNTS:    rdat_d = {ndone_q, nrd_q};
        default:                   rdat_d = 32'h00000000;
      endcase
    end
  end

  // register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      left_q <= 5'h00;
      abort_q <= 1'b0;
      bad_q <= 1'b0;
      ovalid_q <= 1'b0;
      oword_q <= 32'h00000000;
      ohdr_q <= 1'b0;
      obad_q <= 1'b0;
      dack_q <= 1'b0;
      free_q <= 1'b0;
      rdy_q <= 1'b0;
      ctrl_q <= reply_pkg::CTRL_RESET;
      clen_q <= 32'h00000000;
      lasterr_q <= reply_pkg::ERR_NORMAL;
      nrd_q <= 16'h0000;
      ndone_q <= 16'h0000;
      rdat_q <= 32'h00000000;
      ack_q <= 1'b0;
      svalid_q <= 1'b0;
      stream_q <= 5'h00;
      sall_q <= 1'b0;
    end else begin
      state_q <= state_d;
      left_q <= left_d;
      abort_q <= abort_d;
      bad_q <= bad_d;
      ovalid_q <= ovalid_d;
      oword_q <= oword_d;
      ohdr_q <= ohdr_d;
      obad_q <= obad_d;
      dack_q <= dack_d;
      free_q <= free_d;
      rdy_q <= rdy_d;
      ctrl_q <= ctrl_d;
      clen_q <= clen_d;
      lasterr_q <= lasterr_d;
      nrd_q <= nrd_d;
      ndone_q <= ndone_d;
      rdat_q <= rdat_d;
      ack_q <= ack_d;
      svalid_q <= svalid_d;
      stream_q <= stream_d;
      sall_q <= sall_d;
    end
  end

  // outputs straight from flops
  assign dat_o          = rdat_q;
  assign ack_o          = ack_q;
  assign rep_ready_o    = rdy_q;
  assign buf_free_o     = free_q;
  assign data_ack_o     = dack_q;
  assign link_valid_o   = ovalid_q;
  assign link_word_o    = oword_q;
  assign link_hdr_o     = ohdr_q;
  assign link_bad_o     = obad_q;
  assign stream_valid_o = svalid_q;
  assign stream_o       = stream_q;
  assign stream_all_o   = sall_q;

  // checks next to the logic
  property p_read_cmd;
    @(posedge clk_i) disable iff (rst_i)
    take_req && rep_kind_i != reply_pkg::KIND_NO_DATA |=>
      link_hdr_o && link_word_o[5:0] == reply_pkg::CMD_READ_DATA_REPLY;
  endproperty
  a_read_cmd: assert property (p_read_cmd)
    else $error("read reply header wrong");

  property p_done_cmd;
    @(posedge clk_i) disable iff (rst_i)
    take_req && rep_kind_i == reply_pkg::KIND_NO_DATA |=>
      link_word_o[5:0] == reply_pkg::CMD_COMPLETION_NO_DATA && buf_free_o;
  endproperty
  a_done_cmd: assert property (p_done_cmd)
    else $error("completion reply or buffer release wrong");

  property p_byte_count;
    @(posedge clk_i) disable iff (rst_i)
    take_req && rep_kind_i == reply_pkg::KIND_BYTE_READ |=>
      link_word_o[reply_pkg::HB_CNTLO +: 2] == 2'h0 &&
      link_word_o[reply_pkg::HB_CNTHI +: 2] == 2'h0;
  endproperty
  a_byte_count: assert property (p_byte_count)
    else $error("byte read count not zero");

  property p_tag_isoc;
    @(posedge clk_i) disable iff (rst_i)
    take_req |=> link_word_o[reply_pkg::HB_TAG +: 5] == $past(rep_tag_i) &&
      link_word_o[reply_pkg::HB_ISOC] == $past(rep_isoc_i);
  endproperty
  a_tag_isoc: assert property (p_tag_isoc)
    else $error("tag or isoc not copied");

  property p_abort_ones;
    @(posedge clk_i) disable iff (rst_i)
    link_valid_o && !link_hdr_o && abort_q |->
      link_word_o == reply_pkg::ALL_ONES;
  endproperty
  a_abort_ones: assert property (p_abort_ones)
    else $error("master abort data not all ones");

  property p_bad_flag;
    @(posedge clk_i) disable iff (rst_i)
    link_valid_o && !link_hdr_o |->
      link_bad_o == (lasterr_q != reply_pkg::ERR_NORMAL);
  endproperty
  a_bad_flag: assert property (p_bad_flag)
    else $error("unusable data not flagged");

  property p_one_reply;
    @(posedge clk_i) disable iff (rst_i)
    take_req |=> !rep_ready_o;
  endproperty
  a_one_reply: assert property (p_one_reply)
    else $error("second reply accepted too early");

  property p_reqid;
    @(posedge clk_i) disable iff (rst_i)
    take_req && !rep_bridge_i |=>
      link_word_o[reply_pkg::HB_REQID +: 2] == $past(rep_req_unit_i[1:0]);
  endproperty
  a_reqid: assert property (p_reqid)
    else $error("requester id bits wrong");

  property p_downstream;
    @(posedge clk_i) disable iff (rst_i)
    cls_valid_i && !cls_upstream_i |=> stream_valid_o && stream_o == 5'h00;
  endproperty
  a_downstream: assert property (p_downstream)
    else $error("downstream not single stream");

endmodule : reply_framer
`default_nettype wire

// *** design/reply_pkg.sv ***
// reply_pkg: constants for the reply framer, its register map and fields.
// assumes: included before reply_framer; one 125 MHz clock domain.
package reply_pkg;

  // reply command codes and packet geometry
  localparam logic [5:0] CMD_READ_DATA_REPLY  = 6'h30;
  localparam logic [5:0] CMD_COMPLETION_NO_DATA = 6'h33;
  localparam int         TAG_W   = 5;
  localparam int         UNIT_W  = 5;
  localparam int         NUM_UNITS = 32;

  // error code values
  localparam logic [1:0] ERR_NORMAL       = 2'h0;
  localparam logic [1:0] ERR_TARGET_ABORT = 2'h1;
  localparam logic [1:0] ERR_DATA_ERROR   = 2'h2;
  localparam logic [1:0] ERR_MASTER_ABORT = 2'h3;

  // request kinds handed over by the core
  localparam logic [1:0] KIND_DWORD_READ  = 2'h0;
  localparam logic [1:0] KIND_BYTE_READ   = 2'h1;
  localparam logic [1:0] KIND_ATOMIC      = 2'h2;
  localparam logic [1:0] KIND_NO_DATA     = 2'h3;

  // count field values
  localparam logic [3:0] COUNT_ONE_DWORD  = 4'h0;
  localparam logic [3:0] COUNT_ONE_QWORD  = 4'h1;
  localparam logic [3:0] COUNT_ZERO       = 4'h0;
  localparam logic [3:0] COUNT_STEP       = 4'h1;

  // header bit positions inside the 32-bit control word
  localparam int HB_CMD    = 0;
  localparam int HB_ISOC   = 7;
  localparam int HB_UNIT   = 8;
  localparam int HB_BRIDGE = 14;
  localparam int HB_PASS_POSTED_WRITES_FLAG = 15;
  localparam int HB_TAG    = 16;
  localparam int HB_ERR0   = 21;
  localparam int HB_CNTLO  = 22;
  localparam int HB_CNTHI  = 24;
  localparam int HB_CHANNEL_SET_SELECT  = 26;
  localparam int HB_ERR1   = 29;
  localparam int HB_REQID  = 30;

  // channel-set field values derived from the request sequence id
  localparam logic [2:0] CHANNEL_SET_SELECT_ALT    = 3'h0;
  localparam logic [2:0] CHANNEL_SET_SELECT_NONFC  = 3'h1;
  localparam logic [2:0] CHANNEL_SET_SELECT_STREAM = 3'h2;
  localparam logic [2:0] CHANNEL_SET_SELECT_RSV3   = 3'h3;
  localparam logic [2:0] CHANNEL_SET_SELECT_IMPL4  = 3'h4;
  localparam logic [2:0] CHANNEL_SET_SELECT_IMPL6  = 3'h6;
  localparam logic [2:0] CHANNEL_SET_SELECT_NONE   = 3'h0;
  localparam logic [3:0] SEQ_NONFC    = 4'hD;
  localparam logic [3:0] SEQ_IMPL4    = 4'hC;
  localparam logic [3:0] SEQ_RSV_LO   = 4'h8;
  localparam logic [3:0] SEQ_RSV_HI   = 4'h9;
  localparam logic [3:0] SEQ_IMPL6_LO = 4'hA;
  localparam logic [3:0] SEQ_IMPL6_HI = 4'hB;
  localparam logic [3:0] SEQ_ALT_MAX  = 4'h7;

  // register byte addresses
  localparam logic [4:0] ADDR_CTRL      = 5'h00;
  localparam logic [4:0] ADDR_CLUMP_SUP = 5'h04;
  localparam logic [4:0] ADDR_CLUMP_EN  = 5'h08;
  localparam logic [4:0] ADDR_STATUS    = 5'h0C;
  localparam logic [4:0] ADDR_COUNTS    = 5'h10;

  // control register fields and reset value
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_PASSIVE = 1;
  localparam int CTRL_FULL   = 2;
  localparam int CTRL_ISOC_FC = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;

  // host may clump only the lowest four unit identifiers
  localparam logic [31:0] HOST_CLUMP_LIMIT = 32'h0000000F;
  localparam logic [31:0] CLUMP_BIT0_MASK  = 32'hFFFFFFFE;
  localparam logic [31:0] ALL_ONES         = 32'hFFFFFFFF;

endpackage : reply_pkg

// *** verification/link_sink.sv ***
// link_sink: far-end receiver that takes reply words off the link.
// assumes: shares clk_i with the framer; slow_i makes it stall often.
`timescale 1ns/1ps
`default_nettype none
module link_sink (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // link from the framer
  input  wire logic        valid_i,
  input  wire logic [31:0] word_i,
  input  wire logic        hdr_i,
  input  wire logic        bad_i,
  input  wire logic        slow_i,
  output logic             ready_o,
  // each accepted word, shown for one cycle
  output logic             got_o,
  output logic      [31:0] got_word_o,
  output logic             got_hdr_o,
  output logic             got_bad_o
);
  logic stall_q;

  // slow mode refuses every other cycle, even mid-packet
  always_ff @(posedge clk_i) begin
    stall_q <= ~rst_i & slow_i & ~stall_q;
  end
  assign ready_o = ~stall_q;

  // capture a word on the edge where valid and ready meet
  always_ff @(posedge clk_i) begin
    got_o      <= ~rst_i & valid_i & ready_o;
    got_word_o <= word_i;
    got_hdr_o  <= hdr_i;
    got_bad_o  <= bad_i;
  end
endmodule : link_sink
`default_nettype wire

// *** verification/testbench.sv ***
// testbench: drives the reply framer as core and register master.
// assumes: link_sink stands on the link; core data advances on data_ack_o.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [4:0]  adr_i = 5'h00;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic        ack_o, rep_ready_o, buf_free_o, data_ack_o;
  logic        rep_valid_i = 1'b0, rep_isoc_i = 1'b0;
  logic        rep_pass_pw_i = 1'b0, rep_bridge_i = 1'b0;
  logic [1:0]  rep_kind_i = 2'h0, rep_error_i = 2'h0;
  logic [3:0]  rep_count_i = 4'h0, rep_seq_i = 4'h0;
  logic [4:0]  rep_tag_i = 5'h00, rep_unit_i = 5'h06;
  logic [4:0]  rep_req_unit_i = 5'h17;
  logic [31:0] core_word = 32'hA5000000, nx = 32'hA5000000;
  logic        link_ready, link_valid, link_hdr, link_bad, slow = 1'b0;
  logic        isofc = 1'b0;
  logic [31:0] link_word, got_word;
  logic        got, got_hdr, got_bad, stream_valid_o, stream_all_o;
  logic        cls_valid_i = 1'b0, cls_up_i = 1'b0, cls_fence_i = 1'b0;
  logic [4:0]  cls_unit_i = 5'h00, stream_o;
  int          error_cnt = 0, compares = 0, free_cnt = 0;

  // clock, core data source and completion pulse counter
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (data_ack_o) core_word <= core_word + 32'h1;
  always @(posedge clk_i) if (buf_free_o === 1'b1) free_cnt++;

  reply_framer #(.CLUMP_SUPPORT(32'h0000001B), .IS_HOST(1'b0)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rep_valid_i(rep_valid_i), .rep_kind_i(rep_kind_i),
    .rep_count_i(rep_count_i), .rep_error_i(rep_error_i),
    .rep_isoc_i(rep_isoc_i), .rep_pass_pw_i(rep_pass_pw_i),
    .rep_bridge_i(rep_bridge_i), .rep_unit_i(rep_unit_i),
    .rep_req_unit_i(rep_req_unit_i), .rep_tag_i(rep_tag_i),
    .rep_seq_i(rep_seq_i), .rep_ready_o(rep_ready_o),
    .buf_free_o(buf_free_o), .data_valid_i(1'b1), .data_i(core_word),
    .data_ack_o(data_ack_o), .link_ready_i(link_ready),
    .link_valid_o(link_valid), .link_word_o(link_word),
    .link_hdr_o(link_hdr), .link_bad_o(link_bad), .cls_valid_i(cls_valid_i),
    .cls_upstream_i(cls_up_i), .cls_fence_i(cls_fence_i),
    .cls_unit_i(cls_unit_i), .stream_valid_o(stream_valid_o),
    .stream_o(stream_o), .stream_all_o(stream_all_o));

  link_sink sink_u (.clk_i(clk_i), .rst_i(rst_i), .valid_i(link_valid),
    .word_i(link_word), .hdr_i(link_hdr), .bad_i(link_bad), .slow_i(slow),
    .ready_o(link_ready), .got_o(got), .got_word_o(got_word),
    .got_hdr_o(got_hdr), .got_bad_o(got_bad));

  // compare one value and count it
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one classic Wishbone cycle, released after ack is sampled
  task wb(input logic we, input logic [4:0] a, input logic [31:0] d,
          output logic [31:0] q);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, we, a, d};
    // wait for ack as long as it takes; only the watchdog ends a hang
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb

  // wait for the next word accepted by the sink
  task get_word(output logic [31:0] w, output logic h, output logic b);
    int i;
    for (i = 0; i < 60 && got !== 1'b1; i++) @(posedge clk_i);
    if (i == 60) chk(32'h0, 32'h1);
    {w, h, b} = {got_word, got_hdr, got_bad};
    @(posedge clk_i);
  endtask : get_word

  // one reply request, its header fields and every data word
  task run_reply(input logic [1:0] k, input logic [3:0] c,
                 input logic [1:0] e, input logic iso, input logic [4:0] t);
    logic [31:0] w;
    logic        h, b;
    int          n, fr;
    logic [3:0]  ec;
    n = (k == 2'h3) ? 0 : (k == 2'h1) ? 1 : (k == 2'h2) ? 2 : int'(c) + 1;
    ec = (k == 2'h0) ? c : (k == 2'h2) ? 4'h1 : 4'h0;
    {rep_kind_i, rep_count_i, rep_error_i, rep_isoc_i, rep_tag_i} <=
      {k, c, e, iso, t};
    {rep_pass_pw_i, rep_bridge_i, rep_seq_i, rep_valid_i} <=
      {t[0], t[1], 4'hD, 1'b1};
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_i);
      if (rep_ready_o === 1'b1) break;
    end
    rep_valid_i <= 1'b0;
    fr = free_cnt;
    get_word(w, h, b);
    chk(h, 1'b1);
    chk(w[5:0], k == 2'h3 ? 6'h33 : 6'h30);
    chk({w[25:24], w[23:22]}, ec);
    chk({w[29], w[21]}, e);
    chk(w[7], iso);
    chk({w[20:16], w[15], w[12:8]}, {t, t[0], 5'h06});
    chk(w[31:30], t[1] ? 2'h0 : 2'h3);
    chk(w[28:26], (iso && !isofc) ? 3'h1 : 3'h0);
    chk({w[13], w[6]}, 2'h0);
    for (int i = 0; i < n; i++) begin
      get_word(w, h, b);
      chk({h, b}, {1'b0, e != 2'h0});
      chk(w, e == 2'h3 ? 32'hFFFFFFFF : nx);
      if (e != 2'h3) nx = nx + 32'h1;
    end
    repeat (4) @(posedge clk_i);
    chk(free_cnt - fr, k == 2'h3 ? 1 : 0);
    chk(got, 1'b0);
  endtask : run_reply

  // classify one packet and compare the stream result
  task cls(input logic up, input logic f, input logic [4:0] u,
           input logic [5:0] exp);
    {cls_valid_i, cls_up_i, cls_fence_i, cls_unit_i} <= {1'b1, up, f, u};
    repeat (2) @(posedge clk_i);
    chk({stream_valid_o, stream_all_o, f ? 5'h0 : stream_o}, {1'b1, exp});
  endtask : cls

  // print the verdict and stop
  task wrap_up;
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // watchdog against a hang
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  // main sequence
  initial begin
    logic [31:0] q;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 5'h00, 32'h0, q); chk(q, 32'h1);
    wb(1'b1, 5'h04, 32'h0, q);
    wb(1'b0, 5'h04, 32'h0, q); chk(q, 32'h1A);
    wb(1'b1, 5'h08, 32'hFF, q);
    wb(1'b0, 5'h08, 32'h0, q); chk(q, 32'hFE);
    wb(1'b0, 5'h14, 32'h0, q); chk(q, 32'h0);
    for (int k = 0; k < 4; k++)
      for (int e = 0; e < 4; e++) begin
        slow <= k[0];
        run_reply(k[1:0], 4'h3, e[1:0], e[0], 5'(k * 4 + e));
      end
    wb(1'b0, 5'h0C, 32'h0, q);
    chk(q, 32'hC);
    run_reply(2'h0, 4'hF, 2'h0, 1'b0, 5'h1F);
    wb(1'b0, 5'h10, 32'h0, q); chk(q, 32'h0004000D);
    wb(1'b1, 5'h00, 32'h9, q);
    isofc = 1'b1;
    run_reply(2'h3, 4'h0, 2'h0, 1'b1, 5'h02);
    wb(1'b1, 5'h00, 32'h0, q);
    rep_valid_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(rep_ready_o, 1'b0);
    rep_valid_i <= 1'b0;
    wb(1'b1, 5'h00, 32'h1, q);
    cls(1'b1, 1'b0, 5'h09, 6'h09);
    cls(1'b0, 1'b0, 5'h09, 6'h00);
    cls(1'b1, 1'b1, 5'h09, 6'h20);
    wb(1'b1, 5'h00, 32'h5, q);
    wb(1'b1, 5'h08, 32'h18, q);
    cls(1'b1, 1'b0, 5'h04, 6'h02);
    cls(1'b1, 1'b0, 5'h09, 6'h09);
    wb(1'b1, 5'h00, 32'h3, q);
    cls(1'b1, 1'b0, 5'h09, 6'h00);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
